// ---- hps_params.svh ----
// Timing and encoding constants of the hot-plug port selector
`ifndef HPS_PARAMS_SVH
`define HPS_PARAMS_SVH

`define HPS_CLK_NS           100
`define HPS_SETTLE_NS        1000
`define HPS_UNPLUG_NS        2000
`define HPS_MINPULSE_NS      300
`define HPS_REPEAT_NS        200
`define HPS_CNT_W            16
`define HPS_DLY_W            4
`define HPS_SETTLE_CYC       ((`HPS_SETTLE_NS + `HPS_CLK_NS - 1) / `HPS_CLK_NS)
`define HPS_UNPLUG_CYC       ((`HPS_UNPLUG_NS + `HPS_CLK_NS - 1) / `HPS_CLK_NS)
`define HPS_MINPULSE_CYC     ((`HPS_MINPULSE_NS + `HPS_CLK_NS - 1) / `HPS_CLK_NS)
`define HPS_REPEAT_CYC       (`HPS_REPEAT_NS / `HPS_CLK_NS)
`define HPS_PORT_A           1'b0
`define HPS_PORT_B           1'b1

`endif

// ---- hps_pkg.sv ----
// Types shared by the hot-plug port selector
package hps_pkg;
	typedef enum logic [2:0]
	{
		HPS_OFF    = 3'b000,
		HPS_FOLLOW = 3'b001,
		HPS_SETTLE = 3'b010,
		HPS_FORCE  = 3'b011
	} hps_state_t;
endpackage

// ---- hps_delay_line.sv ----
// Fixed-length shift delay for the repeated hot-plug level
`include "hps_params.svh"
`timescale 1ns/10ps
`default_nettype none
module hps_delay_line
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic clr,
	input  wire logic din,
	output logic      dout
);
	typedef struct packed
	{
		logic [`HPS_DLY_W-1:0] sh;
	} hps_dly_t;

	hps_dly_t st_r;
	hps_dly_t st_nxt;

	// Output taps bit 1 of the four-deep shift, the two-cycle repeat delay, so pulse widths pass unchanged
	always_comb
	begin
		st_nxt = st_r;
		if (clr)
			st_nxt.sh = '0;
		else
			st_nxt.sh = {st_r.sh[`HPS_DLY_W-2:0], din};
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign dout = st_r.sh[`HPS_REPEAT_CYC-1];
endmodule // hps_delay_line
`default_nettype wire

// ---- hps_timer.sv ----
// Down-counting timer with restart and expiry pulse
`include "hps_params.svh"
`timescale 1ns/10ps
`default_nettype none
module hps_timer
(
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	input  wire logic                  start,
	input  wire logic                  stop,
	input  wire logic [`HPS_CNT_W-1:0] load,
	output logic                       busy,
	output logic                       done
);
	typedef struct packed
	{
		logic [`HPS_CNT_W-1:0] cnt;
		logic                  busy;
		logic                  done;
	} hps_tmr_t;

	hps_tmr_t st_r;
	hps_tmr_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (stop)
		begin
			st_nxt.busy = 1'b0;
			st_nxt.cnt = '0;
		end
		else if (start)
		begin
			st_nxt.busy = 1'b1;
			st_nxt.cnt = load;
		end
		else if (st_r.busy)
		begin
			if (st_r.cnt <= 16'h0001)
			begin
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
				st_nxt.cnt = '0;
			end
			else
				st_nxt.cnt = st_r.cnt - 16'h0001;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign busy = st_r.busy;
	assign done = st_r.done;
endmodule // hps_timer
`default_nettype wire

// ---- hps_port_select.sv ----
// Port selection and hot-plug repeat logic of a one-in two-out switch
`include "hps_params.svh"
`timescale 1ns/10ps
`default_nettype none
module hps_port_select
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic hot_plug_in_a,
	input  wire logic hot_plug_in_b,
	input  wire logic prio_b,
	input  wire logic low_power_ctl,
	output logic      sel_b,
	output logic      hot_plug_out,
	output logic      hot_plug_out_oe,
	output logic      link_en
);
	typedef struct packed
	{
		hps_pkg::hps_state_t state;
		logic                sel;
		logic                prio;
		logic                hpo;
		logic                hpo_oe;
		logic                link;
		logic [`HPS_CNT_W-1:0] lowcnt;
	} hps_main_t;

	hps_main_t st_r;
	hps_main_t st_nxt;

	// Low-power pin acts as a reset of the control logic
	logic rst_int_n;
	assign rst_int_n = rstn & low_power_ctl;

	logic in_sel;
	logic in_oth;
	logic rep_d;
	logic t_start;
	logic t_stop;
	logic [`HPS_CNT_W-1:0] t_load;
	logic t_busy;
	logic t_done;

	function automatic logic port_in(input logic p, input logic a, input logic b);
		port_in = (p == `HPS_PORT_B) ? b : a;
	endfunction

	assign in_sel = port_in(st_r.sel, hot_plug_in_a, hot_plug_in_b);
	assign in_oth = port_in(~st_r.sel, hot_plug_in_a, hot_plug_in_b);

	hps_delay_line u_dly
	(
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.clr     (st_r.state == hps_pkg::HPS_OFF),
		.din     (in_sel),
		.dout    (rep_d)
	);

	hps_timer u_tmr
	(
		.clk_sys (clk_sys),
		.rstn    (rst_int_n),
		.start   (t_start),
		.stop    (t_stop),
		.load    (t_load),
		.busy    (t_busy),
		.done    (t_done)
	);

	logic pr_port;
	logic pr_in;
	assign pr_port = prio_b ? `HPS_PORT_B : `HPS_PORT_A;
	assign pr_in = port_in(pr_port, hot_plug_in_a, hot_plug_in_b);

	always_comb
	begin
		st_nxt = st_r;
		t_start = 1'b0;
		t_stop = 1'b0;
		t_load = `HPS_CNT_W'(`HPS_UNPLUG_CYC);
		st_nxt.prio = prio_b;
		case (st_r.state)
			hps_pkg::HPS_OFF:
			begin
				st_nxt.hpo = 1'b0;
				st_nxt.hpo_oe = 1'b0;
				st_nxt.link = 1'b0;
				st_nxt.lowcnt = '0;
				if (hot_plug_in_a | hot_plug_in_b)
				begin
					// Both high picks by priority, else the one high
					if (hot_plug_in_a & hot_plug_in_b)
						st_nxt.sel = pr_port;
					else
						st_nxt.sel = hot_plug_in_b ? `HPS_PORT_B : `HPS_PORT_A;
					st_nxt.state = hps_pkg::HPS_FOLLOW;
					st_nxt.hpo_oe = 1'b1;
					st_nxt.link = low_power_ctl;
				end
			end
			hps_pkg::HPS_FOLLOW:
			begin
				st_nxt.hpo = rep_d;
				st_nxt.link = low_power_ctl;
				if (in_sel)
					st_nxt.lowcnt = '0;
				else if (st_r.lowcnt < `HPS_CNT_W'(`HPS_UNPLUG_CYC))
					st_nxt.lowcnt = st_r.lowcnt + 16'h0001;
				if (!in_sel && st_r.lowcnt >= `HPS_CNT_W'(`HPS_UNPLUG_CYC))
				begin
					st_nxt.lowcnt = '0;
					if (in_oth)
						st_nxt.sel = ~st_r.sel;
					else
						st_nxt.state = hps_pkg::HPS_OFF;
				end
				else if (hot_plug_in_a & hot_plug_in_b & (st_r.prio != prio_b))
				begin
					st_nxt.state = hps_pkg::HPS_SETTLE;
					t_start = 1'b1;
					t_load = `HPS_CNT_W'(`HPS_SETTLE_CYC);
				end
				else if ((st_r.sel != pr_port) && pr_in)
				begin
					// Priority port just appeared: emulate an unplug first
					st_nxt.state = hps_pkg::HPS_FORCE;
					st_nxt.hpo = 1'b0;
					t_start = 1'b1;
				end
				// Activity on the non-priority port is ignored here
			end
			hps_pkg::HPS_SETTLE:
			begin
				st_nxt.hpo = rep_d;
				// A further priority edge restarts settling, hiding glitches
				if (st_r.prio != prio_b)
				begin
					t_start = 1'b1;
					t_load = `HPS_CNT_W'(`HPS_SETTLE_CYC);
				end
				else if (t_done)
				begin
					if (st_r.sel != pr_port && pr_in)
					begin
						st_nxt.state = hps_pkg::HPS_FORCE;
						st_nxt.hpo = 1'b0;
						t_start = 1'b1;
					end
					else
						st_nxt.state = hps_pkg::HPS_FOLLOW;
				end
				if (!in_sel)
				begin
					t_stop = 1'b1;
					st_nxt.state = hps_pkg::HPS_FOLLOW;
				end
			end
			hps_pkg::HPS_FORCE:
			begin
				st_nxt.hpo = 1'b0;
				if (!pr_in)
					t_start = 1'b1;
				else if (t_done)
				begin
					st_nxt.sel = pr_port;
					st_nxt.state = hps_pkg::HPS_FOLLOW;
					st_nxt.lowcnt = '0;
				end
				else if (!t_busy)
					t_start = 1'b1;
			end
			default:
				st_nxt.state = hps_pkg::HPS_OFF;
		endcase
	end

	// Reset via low-power pin also drops a running forced-low timer
	always_ff @(posedge clk_sys or negedge rst_int_n)
	begin
		if (!rst_int_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign sel_b = st_r.sel;
	assign hot_plug_out = st_r.hpo;
	assign hot_plug_out_oe = st_r.hpo_oe;
	assign link_en = st_r.link;

	chk_off_no_link: assert property (@(posedge clk_sys) disable iff (!rst_int_n)
		(!hot_plug_in_a && !hot_plug_in_b && st_r.state == hps_pkg::HPS_OFF)
		|=> !link_en) else $error("link active with no sink");
	chk_force_low: assert property (@(posedge clk_sys) disable iff (!rst_int_n)
		st_r.state == hps_pkg::HPS_FORCE |-> !hot_plug_out) else $error("forced low broken");
	chk_force_end: assert property (@(posedge clk_sys) disable iff (!rst_int_n)
		(st_r.state == hps_pkg::HPS_FORCE && t_done && pr_in) |=> sel_b == $past(pr_port))
		else $error("switch after forced low wrong");
	chk_sel_live: assert property (@(posedge clk_sys) disable iff (!rst_int_n)
		(st_r.state == hps_pkg::HPS_FOLLOW && $rose(st_r.state == hps_pkg::HPS_FOLLOW))
		|-> $past(port_in(st_nxt.sel, hot_plug_in_a, hot_plug_in_b)))
		else $error("selected low port");
	chk_wake_link: assert property (@(posedge clk_sys) disable iff (!rst_int_n)
		(st_r.state == hps_pkg::HPS_OFF && (hot_plug_in_a || hot_plug_in_b))
		|=> link_en && hot_plug_out_oe) else $error("no wake");
	chk_lp_no_link: assert property (@(posedge clk_sys) disable iff (!rstn)
		!low_power_ctl |-> !link_en) else $error("link on in low power");
	chk_repeat: assert property (@(posedge clk_sys) disable iff (!rst_int_n)
		(st_r.state == hps_pkg::HPS_FOLLOW)[*4]
		|=> (st_r.state != hps_pkg::HPS_FOLLOW) || (hot_plug_out == $past(rep_d)))
		else $error("repeat wrong");
	chk_settle_first: assert property (@(posedge clk_sys) disable iff (!rst_int_n)
		st_r.state == hps_pkg::HPS_SETTLE
		|-> ($past(st_r.state) == hps_pkg::HPS_FOLLOW) || ($past(st_r.state) == hps_pkg::HPS_SETTLE))
		else $error("settle order");
	cov_force: cover property (@(posedge clk_sys) st_r.state == hps_pkg::HPS_FORCE);
	cov_settle: cover property (@(posedge clk_sys) st_r.state == hps_pkg::HPS_SETTLE);
	cov_unplug: cover property (@(posedge clk_sys) $fell(link_en) && hot_plug_in_a == 1'b0);
endmodule // hps_port_select
`default_nettype wire

// ---- hps_far_model.sv ----
// Sink connectors and source hot-plug receiver around the port selector
`timescale 1ns/10ps
`default_nettype none
module hps_far_model
(
	input  wire logic clk_sys,
	input  wire logic want_a,
	input  wire logic want_b,
	input  wire logic hot_plug_out,
	input  wire logic hot_plug_out_oe,
	output logic      hot_plug_in_a = 1'b0,
	output logic      hot_plug_in_b = 1'b0,
	output logic      src_hpd
);
	// Sinks move their level just after an edge, as a connector would
	always_ff @(posedge clk_sys)
	begin
		hot_plug_in_a <= want_a;
		hot_plug_in_b <= want_b;
	end
	// Source input has a pull-down, so an undriven line reads low
	assign src_hpd = hot_plug_out_oe ? hot_plug_out : 1'b0;
endmodule // hps_far_model
`default_nettype wire

// ---- test_hps_port_select.sv ----
// Self-checking bench of the hot-plug port selector
`timescale 1ns/10ps
`default_nettype none
module test_hps_port_select;
	logic  clk_sys = 1'b0;
	logic  rstn = 1'b0;
	logic  want_a = 1'b0;
	logic  want_b = 1'b0;
	logic  prio_b = 1'b0;
	logic  low_power_ctl = 1'b1;
	logic  hot_plug_in_a;
	logic  hot_plug_in_b;
	logic  sel_b;
	logic  hot_plug_out;
	logic  hot_plug_out_oe;
	logic  link_en;
	logic  src_hpd;
	int    mismatches = 0;
	int    num_checks = 0;
	string names[4] = '{"sel_b", "src_hpd", "link_en", "oe"};
	always #50 clk_sys = ~clk_sys;
	hps_port_select dut
	(
		.clk_sys(clk_sys), .rstn(rstn), .hot_plug_in_a(hot_plug_in_a),
		.hot_plug_in_b(hot_plug_in_b), .prio_b(prio_b), .low_power_ctl(low_power_ctl),
		.sel_b(sel_b), .hot_plug_out(hot_plug_out), .hot_plug_out_oe(hot_plug_out_oe),
		.link_en(link_en)
	);
	hps_far_model far
	(
		.clk_sys(clk_sys), .want_a(want_a), .want_b(want_b), .hot_plug_out(hot_plug_out),
		.hot_plug_out_oe(hot_plug_out_oe), .hot_plug_in_a(hot_plug_in_a),
		.hot_plug_in_b(hot_plug_in_b), .src_hpd(src_hpd)
	);
	function automatic logic probe(input int k);
		case (k)
			0: return sel_b;
			1: return src_hpd;
			2: return link_en;
			default: return hot_plug_out_oe;
		endcase
	endfunction
	task automatic wrap_up();
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string what, input logic exp, input logic seen);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %b, seen %b", what, exp, seen);
		end
	endtask
	// Stay=1: level must hold n cycles; stay=0: must arrive within n cycles
	task automatic watch(input int k, input logic exp, input int n, input logic stay);
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk_sys);
			if ((probe(k) === exp) != stay)
				break;
		end
		check(names[k], exp, probe(k));
		if (!stay && probe(k) !== exp)
			wrap_up();
	endtask
	task automatic drv(input logic a, input logic b, input logic p, input logic lp);
		@(posedge clk_sys);
		want_a <= a;
		want_b <= b;
		prio_b <= p;
		low_power_ctl <= lp;
	endtask
	task automatic sc_wake();
		watch(3, 1'b0, 5, 1'b1);
		drv(0, 1, 0, 0);
		watch(2, 1'b0, 10, 1'b1);
		drv(0, 1, 0, 1);
		watch(0, 1'b1, 5, 1'b0);
		watch(2, 1'b1, 5, 1'b0);
		watch(1, 1'b1, 8, 1'b0);
		drv(0, 1, 1, 1);
		drv(0, 1, 0, 1);
		watch(0, 1'b1, 30, 1'b1);
	endtask
	task automatic sc_pulse();
		int n;
		int first;
		n = 0;
		first = 99;
		// Input held low for four cycles; the output must copy that width
		drv(0, 0, 0, 1);
		for (int i = 0; i < 14; i++)
		begin
			@(negedge clk_sys);
			if (src_hpd === 1'b0)
			begin
				n++;
				if (first == 99)
					first = i;
			end
			if (i == 3)
				drv(0, 1, 0, 1);
		end
		check("repeat delay", 1'b1, first < 6);
		check("pulse width", 1'b1, n == 4);
	endtask
	task automatic sc_unplug_lone();
		drv(0, 0, 0, 1);
		watch(2, 1'b1, 15, 1'b1);
		watch(2, 1'b0, 15, 1'b0);
		drv(0, 1, 0, 1);
		watch(2, 1'b1, 5, 1'b0);
	endtask
	task automatic sc_prio_arrive();
		drv(1, 1, 0, 1);
		watch(1, 1'b0, 6, 1'b0);
		watch(0, 1'b1, 8, 1'b1);
		drv(0, 1, 0, 1);
		drv(1, 1, 0, 1);
		watch(0, 1'b1, 17, 1'b1);
		watch(0, 1'b0, 15, 1'b0);
		watch(1, 1'b1, 8, 1'b0);
	endtask
	task automatic sc_ignore();
		drv(1, 0, 0, 1);
		watch(1, 1'b1, 25, 1'b1);
		drv(1, 1, 0, 1);
		watch(1, 1'b1, 25, 1'b1);
		watch(0, 1'b0, 1, 1'b1);
	endtask
	task automatic sc_prio_toggle();
		drv(1, 1, 1, 1);
		drv(1, 1, 0, 1);
		watch(1, 1'b1, 40, 1'b1);
		drv(1, 1, 1, 1);
		watch(1, 1'b1, 8, 1'b1);
		watch(1, 1'b0, 8, 1'b0);
		watch(0, 1'b0, 15, 1'b1);
		watch(0, 1'b1, 10, 1'b0);
		watch(1, 1'b1, 8, 1'b0);
	endtask
	task automatic sc_unplug_both();
		drv(1, 0, 1, 1);
		watch(0, 1'b1, 15, 1'b1);
		watch(0, 1'b0, 15, 1'b0);
	endtask
	task automatic sc_lp_cancel();
		drv(1, 1, 1, 1);
		watch(1, 1'b0, 6, 1'b0);
		// Short low-power pulse; the logic restarts with both sinks present
		drv(1, 1, 1, 0);
		drv(1, 1, 1, 1);
		watch(0, 1'b1, 8, 1'b0);
		watch(1, 1'b1, 8, 1'b0);
	endtask
	initial
	begin
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		sc_wake();
		sc_pulse();
		sc_unplug_lone();
		sc_prio_arrive();
		sc_ignore();
		sc_prio_toggle();
		sc_unplug_both();
		sc_lp_cancel();
		wrap_up();
	end
endmodule // test_hps_port_select
`default_nettype wire
